// File: rtl/rst_seq_pkg.sv
// constants and types shared by the reset sequencer files
// How it works
// - five reset sources: pin, brown-out, software, watchdog, oscillation stop
// - pins are forced to their reset state while the reset input is low
// - the reset input low also restarts the main oscillator
// - cpu and special function regs reset through the reset input rising edge
// - after reset, execution starts at the reset vector address
// - internal ram is never cleared or initialised by any reset
// - a ram write cut by reset may be lost; no protection is given
// - pin or brown-out reset loads pull-up one from boot pin: 00h or 02h
// - soft, watchdog, osc-stop reset load pull-up one from mode bits: 00h or 02h
// - software reset keeps the processor mode bits unchanged
// - brown-out reset acts like the external pin reset, except that it sets its own status cause bit
package rst_seq_pkg;
  localparam int PADDR_W = 16;
  // printed offset is a byte-register index; bus address is four times it
  localparam logic [PADDR_W-1:0] PULLUP_ONE_IDX = 16'h03FD;
  localparam logic [PADDR_W-1:0] MODE_CTRL_IDX = 16'h0400;
  localparam logic [PADDR_W-1:0] RESET_STAT_IDX = 16'h0401;
  localparam logic [PADDR_W-1:0] PULLUP_ONE_ADDR = PULLUP_ONE_IDX << 2;
  localparam logic [PADDR_W-1:0] MODE_CTRL_ADDR = MODE_CTRL_IDX << 2;
  localparam logic [PADDR_W-1:0] RESET_STAT_ADDR = RESET_STAT_IDX << 2;
  localparam logic [7:0] PULLUP_ONE_RST = 8'h00;
  localparam logic [7:0] PULLUP_ONE_EXP = 8'h02;
  localparam int MODE_PM_LSB = 0;
  localparam int MODE_SWRST_BIT = 3;
  localparam int STAT_BUSY_BIT = 5;
  localparam logic [1:0] PM_SINGLE_CHIP = 2'h0;
  localparam int MIN_LOW_CYCLES = 20;
  localparam int RELEASE_CYCLES = 28;
  localparam logic [19:0] RESET_VECTOR_ADDR = 20'hFFFFC;
  typedef logic [1:0] pm_t;
  typedef logic [4:0] cause_t;
  localparam int CAUSE_PIN = 0;
  localparam int CAUSE_BROWNOUT = 1;
  localparam int CAUSE_SOFTWARE = 2;
  localparam int CAUSE_WATCHDOG = 3;
  localparam int CAUSE_OSC_STOP = 4;
  typedef enum logic [1:0] {ST_RUN, ST_HOLD, ST_RELEASE, ST_VECTOR} state_e;
endpackage

// File: rtl/rst_sync_if.sv
// synchronised hardware reset levels between synchroniser and sequencer
`timescale 1ns/100ps
interface rst_sync_if;
  logic pin_low;
  logic brownout;
  modport src (output pin_low, output brownout);
  modport dst (input pin_low, input brownout);
endinterface

// File: rtl/reset_input_sync.sv
// two-flop synchronisers for the reset pin and brown-out level
`timescale 1ns/100ps
module reset_input_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic reset_pin_n,
  input wire logic brownout_det,
  rst_sync_if.src sync
);
  logic [1:0] pin_q, pin_d;
  logic [1:0] bod_q, bod_d;

  // stage 0 feeds only stage 1; release never reaches logic unsynchronised
  always_comb begin
    pin_d = {pin_q[0], ~reset_pin_n};
    bod_d = {bod_q[0], brownout_det};
  end

  // comes out of presetn holding reset active
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_q <= 2'h3;
      bod_q <= 2'h0;
    end else begin
      pin_q <= pin_d;
      bod_q <= bod_d;
    end
  end

  assign sync.pin_low = pin_q[1];
  assign sync.brownout = bod_q[1];
endmodule

// File: rtl/mcu_reset_sequencer.sv
// reset sequencer with its apb-reached pull-up, mode and status registers
`timescale 1ns/100ps
module mcu_reset_sequencer #(
  parameter int RELEASE_CYCLES = rst_seq_pkg::RELEASE_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [rst_seq_pkg::PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic reset_pin_n,
  input wire logic brownout_det,
  input wire logic watchdog_underflow,
  input wire logic osc_stop_det,
  input wire logic boot_mode_pin,
  output logic pin_reset_q,
  output logic osc_restart_q,
  output logic cpu_reset_q,
  output logic special_function_regs_reset_q,
  output logic vector_fetch_q,
  output logic [19:0] vector_addr_q,
  output rst_seq_pkg::pm_t processor_mode_bits,
  output logic [7:0] pullup_control_one
);
  import rst_seq_pkg::*;

  localparam int CNT_W = $clog2(RELEASE_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(RELEASE_CYCLES - 1);

  rst_sync_if sync ();

  reset_input_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .reset_pin_n(reset_pin_n),
    .brownout_det(brownout_det),
    .sync(sync)
  );

  state_e state_q, state_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  pm_t pm_q, pm_d;
  logic [7:0] pur_q, pur_d;
  cause_t cause_q, cause_d;
  logic pin_rst_d, osc_rst_d, cpu_rst_d, special_function_regs_rst_d, vec_d;
  logic [19:0] vaddr_q, vaddr_d;
  logic [31:0] rdata_q, rdata_d;
  logic ready_q, ready_d, err_q, err_d;

  logic hw_hold, wr_en, sw_req, soft_evt, hit_pur, hit_mode, hit_stat;

  // brown-out takes the very same path as the pin
  assign hw_hold = sync.pin_low | sync.brownout;
  assign wr_en = psel & penable & ready_q & pwrite;

  always_comb begin
    hit_pur = 1'b0;
    hit_mode = 1'b0;
    hit_stat = 1'b0;
    if (paddr == PULLUP_ONE_ADDR) begin
      hit_pur = 1'b1;
    end else if (paddr == MODE_CTRL_ADDR) begin
      hit_mode = 1'b1;
    end else if (paddr == RESET_STAT_ADDR) begin
      hit_stat = 1'b1;
    end
  end

  assign sw_req = wr_en & hit_mode & pwdata[MODE_SWRST_BIT];
  assign soft_evt = sw_req | watchdog_underflow | osc_stop_det;

  // apb: one wait-free access cycle, answer registered in the setup cycle
  always_comb begin
    ready_d = psel & ~penable;
    err_d = psel & ~penable & ~(hit_pur | hit_mode | hit_stat);
    rdata_d = 32'h0;
    if (psel && !penable && !pwrite) begin
      if (hit_pur) begin
        rdata_d[7:0] = pur_q;
      end else if (hit_mode) begin
        rdata_d[MODE_PM_LSB +: 2] = pm_q;
      end else if (hit_stat) begin
        rdata_d[4:0] = cause_q;
        rdata_d[STAT_BUSY_BIT] = (state_q != ST_RUN);
      end
    end
  end

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    pm_d = pm_q;
    pur_d = pur_q;
    cause_d = cause_q;
    vaddr_d = vaddr_q;
    // software stores first; any reset load below overrides it
    if (wr_en && hit_pur) begin
      pur_d = pwdata[7:0];
    end
    if (wr_en && hit_mode) begin
      pm_d = pwdata[MODE_PM_LSB +: 2];
    end
    case (state_q)
      ST_RUN: begin
        if (hw_hold) begin
          state_d = ST_HOLD;
        end else if (soft_evt) begin
          state_d = ST_RELEASE;
          cnt_d = '0;
          pm_d = pm_q;
          cause_d = '0;
          cause_d[CAUSE_SOFTWARE] = sw_req;
          cause_d[CAUSE_WATCHDOG] = watchdog_underflow;
          cause_d[CAUSE_OSC_STOP] = osc_stop_det;
          // mode 10b is not defined; treated as an expansion mode
          pur_d = (pm_q == PM_SINGLE_CHIP) ? PULLUP_ONE_RST : PULLUP_ONE_EXP;
        end
      end
      ST_HOLD: begin
        // latched only while held, else the release cycle would wipe the cause
        if (hw_hold) begin
          cause_d = '0;
          cause_d[CAUSE_PIN] = sync.pin_low;
          cause_d[CAUSE_BROWNOUT] = sync.brownout;
        end
        // cpu and regs are released only after the synchronised rising edge and the release count
        if (!hw_hold) begin
          state_d = ST_RELEASE;
          cnt_d = '0;
          pm_d = PM_SINGLE_CHIP;
          pur_d = boot_mode_pin ? PULLUP_ONE_EXP : PULLUP_ONE_RST;
        end
      end
      ST_RELEASE: begin
        if (hw_hold) begin
          state_d = ST_HOLD;
        end else if (cnt_q == CNT_LAST) begin
          state_d = ST_VECTOR;
          vaddr_d = RESET_VECTOR_ADDR;
        end else begin
          cnt_d = cnt_q + 1'b1;
        end
      end
      ST_VECTOR: begin
        state_d = hw_hold ? ST_HOLD : ST_RUN;
      end
      default: begin
        state_d = ST_HOLD;
      end
    endcase
    // ram has no port here: it keeps its data, and a write cut short is
    // left to the ram itself
  end

  always_comb begin
    pin_rst_d = (state_d == ST_HOLD) || (state_d == ST_RELEASE);
    osc_rst_d = (state_d == ST_HOLD);
    cpu_rst_d = pin_rst_d;
    special_function_regs_rst_d = pin_rst_d;
    vec_d = (state_d == ST_VECTOR);
  end

  // pin release relies on the far side giving the oscillator enough clocks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_HOLD;
      cnt_q <= '0;
      pm_q <= PM_SINGLE_CHIP;
      pur_q <= PULLUP_ONE_RST;
      cause_q <= '0;
      vaddr_q <= '0;
      rdata_q <= 32'h0;
      ready_q <= 1'b0;
      err_q <= 1'b0;
      pin_reset_q <= 1'b1;
      osc_restart_q <= 1'b1;
      cpu_reset_q <= 1'b1;
      special_function_regs_reset_q <= 1'b1;
      vector_fetch_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      pm_q <= pm_d;
      pur_q <= pur_d;
      cause_q <= cause_d;
      vaddr_q <= vaddr_d;
      rdata_q <= rdata_d;
      ready_q <= ready_d;
      err_q <= err_d;
      pin_reset_q <= pin_rst_d;
      osc_restart_q <= osc_rst_d;
      cpu_reset_q <= cpu_rst_d;
      special_function_regs_reset_q <= special_function_regs_rst_d;
      vector_fetch_q <= vec_d;
    end
  end

  assign prdata = rdata_q;
  assign pready = ready_q;
  assign pslverr = err_q;
  assign vector_addr_q = vaddr_q;
  assign processor_mode_bits = pm_q;
  assign pullup_control_one = pur_q;
endmodule

// File: verif/rst_seq_checker_assertions.sv
// port assertions for the reset sequencer
`timescale 1ns/100ps
module rst_seq_checker #(
  parameter int RELEASE_CYCLES = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic reset_pin_n,
  input wire logic brownout_det,
  input wire logic watchdog_underflow,
  input wire logic osc_stop_det,
  input wire logic boot_mode_pin,
  input wire logic pin_reset_q,
  input wire logic osc_restart_q,
  input wire logic cpu_reset_q,
  input wire logic special_function_regs_reset_q,
  input wire logic vector_fetch_q,
  input wire logic [19:0] vector_addr_q,
  input wire rst_seq_pkg::pm_t processor_mode_bits,
  input wire logic [7:0] pullup_control_one
);
  import rst_seq_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence hw_leave;
    $fell(osc_restart_q);
  endsequence
  sequence soft_evt;
    (watchdog_underflow || osc_stop_det) && !cpu_reset_q && !vector_fetch_q;
  endsequence
  pin_hold_a: assert property (!reset_pin_n [*4] |-> pin_reset_q && osc_restart_q)
    else $error("pin low without reset hold");
  brownout_hold_a: assert property (brownout_det [*4] |-> pin_reset_q && cpu_reset_q)
    else $error("brown-out without reset hold");
  sync_release_a: assert property ($rose(reset_pin_n) && osc_restart_q |->
    osc_restart_q [*2]) else $error("release not synchronised");
  cpu_hold_a: assert property (hw_leave |->
    (cpu_reset_q && special_function_regs_reset_q) [*2]) else $error("cpu released too early");
  osc_scope_a: assert property (osc_restart_q |-> pin_reset_q && cpu_reset_q)
    else $error("osc restart outside hold");
  vector_pulse_a: assert property (vector_fetch_q |=> !vector_fetch_q &&
    vector_addr_q == RESET_VECTOR_ADDR) else $error("bad vector fetch");
  vector_run_a: assert property (vector_fetch_q |-> ##[0:1] !cpu_reset_q)
    else $error("no run after vector");
  boot_load_a: assert property (hw_leave |-> processor_mode_bits == PM_SINGLE_CHIP &&
    pullup_control_one == {6'h00, boot_mode_pin, 1'h0}) else $error("bad boot load");
  soft_load_a: assert property ($rose(cpu_reset_q) && !osc_restart_q |->
    $stable(processor_mode_bits) && pullup_control_one ==
    (processor_mode_bits == PM_SINGLE_CHIP ? 8'h00 : 8'h02)) else $error("bad soft load");
  soft_take_a: assert property (soft_evt |=> pin_reset_q && cpu_reset_q)
    else $error("soft event ignored");
endmodule
bind mcu_reset_sequencer rst_seq_checker #(.RELEASE_CYCLES(RELEASE_CYCLES)) i_rst_seq_checker (.*);

// File: verif/ext_reset_model.sv
// external reset circuit pulling the reset input low on request
`timescale 1ns/100ps
module ext_reset_model #(
  parameter int LOW_CYCLES = 20
) (
  input wire logic pclk,
  input wire logic trigger,
  input wire logic slow,
  output logic reset_pin_n
);
  int cnt_q = 0;
  // slow stretches the low time, never below the minimum
  always @(posedge pclk) begin
    if (trigger && cnt_q == 0) begin
      cnt_q <= slow ? 3 * LOW_CYCLES : LOW_CYCLES;
    end else if (cnt_q != 0) begin
      cnt_q <= cnt_q - 1;
    end
    reset_pin_n <= !(trigger || cnt_q > 1);
  end
endmodule

// File: verif/mcu_reset_sequencer_test.sv
// self-checking bench for the reset sequencer
`timescale 1ns/100ps
module mcu_reset_sequencer_test;
  import rst_seq_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, trigger, slow, reset_pin_n;
  logic brownout_det, watchdog_underflow, osc_stop_det, boot_mode_pin;
  logic pin_reset_q, osc_restart_q, cpu_reset_q, special_function_regs_reset_q, vector_fetch_q;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [19:0] vector_addr_q;
  pm_t processor_mode_bits;
  logic [7:0] pullup_control_one;
  int err_count = 0;
  int num_checks = 0;
  logic [15:0] t_addr [5] = '{PULLUP_ONE_ADDR, 16'h0FF8, MODE_CTRL_ADDR, PULLUP_ONE_ADDR,
    MODE_CTRL_ADDR};
  logic [31:0] t_data [5] = '{32'hFF, 32'h5A, 32'h3, 32'hA5, 32'h1};
  logic [31:0] t_exp [5] = '{32'hFF, 32'h0, 32'h3, 32'hA5, 32'h1};
  logic t_err [5] = '{1'h0, 1'h1, 1'h0, 1'h0, 1'h0};
  mcu_reset_sequencer #(.RELEASE_CYCLES(2)) i_mcu_reset_sequencer (.*);
  ext_reset_model i_ext_reset_model (.*);
  initial begin
    pclk = 1'h0;
    forever #4 pclk = ~pclk;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    // no fixed wait count: only the watchdog ends a stuck transfer
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // bounded wait for the vector fetch, then check the outcome
  task automatic after_reset(input string nm, input logic [5:0] st, input logic [7:0] pu,
    input pm_t pm);
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (vector_fetch_q !== 1'h1 && n < 300);
    chk("vector seen", {31'h0, vector_fetch_q}, 32'h1);
    apb(1'h0, RESET_STAT_ADDR, 32'h0);
    chk("status", rd & 32'h3F, {26'h0, st});
    chk("pull-up one", {24'h0, pullup_control_one}, {24'h0, pu});
    chk("mode bits", {30'h0, processor_mode_bits}, {30'h0, pm});
    chk("vector addr", {12'h0, vector_addr_q}, {12'h0, RESET_VECTOR_ADDR});
    $display("test %s done", nm);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #100000;
    err_count++;
    tally_and_finish();
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {brownout_det, watchdog_underflow, osc_stop_det, boot_mode_pin, trigger, slow} = '0;
    repeat (8) @(posedge pclk);
    presetn <= 1'h1;
    after_reset("power-up", 6'h01, 8'h00, 2'h0);
    for (int i = 0; i < 5; i++) begin
      apb(1'h1, t_addr[i], t_data[i]);
      apb(1'h0, t_addr[i], 32'h0);
      chk("reg read", rd, t_exp[i]);
      chk("slverr", {31'h0, er}, {31'h0, t_err[i]});
    end
    $display("test registers done");
    apb(1'h1, MODE_CTRL_ADDR, 32'h9);
    after_reset("software", 6'h04, 8'h02, 2'h1);
    watchdog_underflow <= 1'h1;
    @(posedge pclk);
    watchdog_underflow <= 1'h0;
    after_reset("watchdog", 6'h08, 8'h02, 2'h1);
    osc_stop_det <= 1'h1;
    @(posedge pclk);
    osc_stop_det <= 1'h0;
    after_reset("osc stop", 6'h10, 8'h02, 2'h1);
    boot_mode_pin <= 1'h1;
    slow <= 1'h1;
    trigger <= 1'h1;
    @(posedge pclk);
    trigger <= 1'h0;
    repeat (6) @(posedge pclk);
    chk("pins held", {30'h0, pin_reset_q, osc_restart_q}, 32'h3);
    after_reset("pin", 6'h01, 8'h02, 2'h0);
    boot_mode_pin <= 1'h0;
    apb(1'h1, MODE_CTRL_ADDR, 32'h1);
    brownout_det <= 1'h1;
    repeat (25) @(posedge pclk);
    brownout_det <= 1'h0;
    after_reset("brownout", 6'h02, 8'h00, 2'h0);
    // presetn in mid-run: registers and outputs go back to their reset values
    apb(1'h1, PULLUP_ONE_ADDR, 32'h5A);
    apb(1'h1, MODE_CTRL_ADDR, 32'h3);
    @(posedge pclk);
    presetn <= 1'h0;
    repeat (3) @(posedge pclk);
    chk("reset regs", {22'h0, pullup_control_one, processor_mode_bits}, 32'h0);
    chk("reset outs", {29'h0, pin_reset_q, cpu_reset_q, osc_restart_q}, 32'h7);
    chk("reset apb", {30'h0, pready, pslverr}, 32'h0);
    chk("reset read", prdata, 32'h0);
    presetn <= 1'h1;
    after_reset("presetn", 6'h01, 8'h00, 2'h0);
    tally_and_finish();
  end
endmodule
